//--- core/icef_pkg.sv
// Package for the input capture event FIFO: register map, fields, modes, timing
package icef_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] ADDR_CONTROL_ONE = 2'h0;  // capture_control_one
  localparam logic [1:0] ADDR_FIFO_PORT   = 2'h1;  // capture_fifo_port
  localparam logic [1:0] ADDR_IRQ_CTRL    = 2'h2;  // flag, enable, priority
  // Field positions in capture_control_one
  localparam int MODE_LSB   = 0;
  localparam int BNE_BIT    = 3;
  localparam int OV_BIT     = 4;
  localparam int CPI_LSB    = 5;
  localparam int SIDL_BIT   = 13;
  // Field positions in the interrupt control register
  localparam int IRQF_BIT   = 0;
  localparam int IRQE_BIT   = 1;
  localparam int PRIO_LSB   = 2;
  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] CPI_RST  = 2'h0;
  localparam logic [2:0] PRIO_RST = 3'h0;
  // Prescale targets
  localparam logic [3:0] PRE_FOUR    = 4'h3;
  localparam logic [3:0] PRE_SIXTEEN = 4'hf;
  // Flag delay after the buffer write, in instruction cycles
  localparam int IRQ_DELAY_CYC = 2;

  typedef enum logic [2:0] {
    ICEF_OFF     = 3'b000,
    ICEF_BOTH    = 3'b001,
    ICEF_FALL    = 3'b010,
    ICEF_RISE    = 3'b011,
    ICEF_PRE4    = 3'b100,
    ICEF_PRE16   = 3'b101,
    ICEF_DISABLE = 3'b110,
    ICEF_SLEEPIRQ = 3'b111
  } icef_mode_t;

  typedef struct packed {
    logic        stop_in_idle;
    logic [1:0]  captures_per_interrupt;
    icef_mode_t  capture_mode_select;
  } icef_cfg_t;
endpackage : icef_pkg

//--- core/icef_capture.sv
// Input capture channel with four-entry event FIFO and interrupt logic
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Mode off or reset clears the edge prescaler counter.
// - Switching between active modes keeps the prescaler count.
// - Both-edges mode captures every edge without the prescaler.
// - Both-edges mode flags every capture, ignoring captures-per-interrupt.
// - Interrupt flag rises two cycles after the buffer write.
// - Pin edges are synchronised, then the timer value is written.
// - Stored value is the timer two to three counts after the edge.
// - Mode off clears overflow and empties the FIFO.
// - Buffer-not-empty sets on first capture, clears when all read.
// - Four entries; reads shift remaining entries forward.
// - Capture into full buffer sets overflow, is dropped, no interrupt.
// - Fourth read, mode off or reset clears overflow.
// - Overflow only in capture modes, full, capture, not idle-stopped sleep mode.
// - Count zero or both-edges: interrupts continue, overflow stays clear.
// - Count zero makes the channel an external interrupt input.
// - Interrupt after field value plus one buffer writes, field bits 6:5.
// - Otherwise no interrupts while overflow persists.
// - Buffer becoming empty resets the interrupt event counter.
// - Sleep-interrupt mode: rising edge wakes device, raises enabled interrupt.
// - Other modes never wake from Sleep.
// - Stop-in-idle bit 13: clear runs in Idle, set behaves as Sleep.
// - Code 011 captures rising, 010 falling, no prescaler.
// - Codes 100 and 101 capture every fourth or sixteenth rising edge.
// - Port reads return the oldest FIFO entry.
module icef_capture #(
  parameter int TW    = 16,
  parameter int DEPTH = 4
) (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           capture_input_pin,
  input  wire logic [TW-1:0]  timer_count,
  input  wire logic           sleep_mode,
  input  wire logic           idle_mode,
  input  wire logic [2:0]     cpu_priority,
  input  wire logic [1:0]     reg_addr,
  input  wire logic [15:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [15:0]    reg_rdata,
  output logic                capture_irq,
  output logic                wake_request
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] ZERO_CNT = '0;
  localparam logic [CW-1:0] ONE_CNT  = CW'(1);
  localparam int IRQ_DELAY_W = icef_pkg::IRQ_DELAY_CYC;

  // Fill counter has one spare code so full and empty differ
  // Flag delay line length follows the package timing count
  // Overflow read counter shares the fill width, so depth may grow
  // Timer words wider than the port are cut to their low 16 bits on read

  //////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; first stage read only by the second
  // The pin is asynchronous, so two flops guard against metastability
  // A third flop keeps the previous settled level for edge detection
  // All three reset low to match an idle low pin: no false edge
  // Latency is fixed, so capture spacing equals edge spacing
  logic sync_a;
  logic sync_b;
  logic pin_prev;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a   <= 1'b0;
      sync_b   <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      sync_a   <= capture_input_pin;
      sync_b   <= sync_a;
      pin_prev <= sync_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State declarations
  // Every group has a next_ value built in one combinational block
  // and registered in the single clocked block further down
  // FIFO storage is plain flops; entry 0 is always the oldest
  icef_pkg::icef_cfg_t      cfg, next_cfg;
  logic                     irq_en, next_irq_en;
  logic [2:0]               irq_prio, next_irq_prio;
  logic                     irq_flag, next_irq_flag;
  logic [3:0]               pre_cnt, next_pre_cnt;
  logic [TW-1:0]            fifo [DEPTH];
  logic [TW-1:0]            next_fifo [DEPTH];
  logic [CW-1:0]            fill, next_fill;
  logic                     ovf, next_ovf;
  logic [1:0]               ev_cnt, next_ev_cnt;
  logic [CW-1:0]            ovf_reads, next_ovf_reads;
  logic [IRQ_DELAY_W-1:0]   irq_pipe, next_irq_pipe;
  logic                     wake, next_wake;
  logic [15:0]              rdata, next_rdata;

  //////////////////////////////////////////////////////////////////////////
  // Event qualification
  // Turns settled pin edges into capture events for the current mode
  // Prescaled modes only fire on the rising edge that ends a count
  // Sleep or stopped Idle freezes every mode but sleep-interrupt
  // Overflow is judged here so the write path sees one clean decision
  // Hazard: a capture and a mode-off write in one cycle; off wins below
  logic rise, fall, stopped, capture_ev, pre_hit;
  logic do_write, do_ovf, want_irq, rd_fifo, mode_off_wr;
  icef_pkg::icef_mode_t mode;
  always_comb begin
    mode    = cfg.capture_mode_select;
    rise    = sync_b & ~pin_prev;
    fall    = ~sync_b & pin_prev;
    // Idle with stop set behaves as Sleep
    stopped = sleep_mode | (idle_mode & cfg.stop_in_idle);
    pre_hit = 1'b0;
    capture_ev = 1'b0;
    case (mode)
      icef_pkg::ICEF_BOTH:  capture_ev = rise | fall;
      icef_pkg::ICEF_FALL:  capture_ev = fall;
      icef_pkg::ICEF_RISE:  capture_ev = rise;
      icef_pkg::ICEF_PRE4: begin
        pre_hit    = rise & (pre_cnt[1:0] == icef_pkg::PRE_FOUR[1:0]);
        capture_ev = pre_hit;
      end
      icef_pkg::ICEF_PRE16: begin
        pre_hit    = rise & (pre_cnt == icef_pkg::PRE_SIXTEEN);
        capture_ev = pre_hit;
      end
      icef_pkg::ICEF_SLEEPIRQ: capture_ev = rise;
      default:              capture_ev = 1'b0;
    endcase
    // Sleep stops the clocked capture path except in sleep-interrupt mode
    if (stopped && mode != icef_pkg::ICEF_SLEEPIRQ) begin
      capture_ev = 1'b0;
    end
    rd_fifo     = reg_rd && reg_addr == icef_pkg::ADDR_FIFO_PORT && fill != ZERO_CNT;
    mode_off_wr = reg_wr && reg_addr == icef_pkg::ADDR_CONTROL_ONE &&
                  reg_wdata[icef_pkg::MODE_LSB +: 3] == 3'h0;
    // Sleep-interrupt mode while stopped: value is invalid, nothing stored
    do_write = capture_ev && fill != FULL_CNT && !ovf &&
               !(stopped && mode == icef_pkg::ICEF_SLEEPIRQ);
    do_ovf   = capture_ev && fill == FULL_CNT &&
               mode != icef_pkg::ICEF_BOTH &&
               cfg.captures_per_interrupt != 2'h0 &&
               !(stopped && mode == icef_pkg::ICEF_SLEEPIRQ);
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  // Order matters: read, then write, then flag, then mode off
  // Later assignments override earlier ones, so mode off beats the read and write paths
  // and a hardware flag set beats a software clear
  // Read and write may share a cycle; the read shifts first, but a full buffer still drops the write
  always_comb begin
    next_cfg       = cfg;
    next_irq_en    = irq_en;
    next_irq_prio  = irq_prio;
    next_irq_flag  = irq_flag;
    next_pre_cnt   = pre_cnt;
    next_fill      = fill;
    next_ovf       = ovf;
    next_ev_cnt    = ev_cnt;
    next_ovf_reads = ovf_reads;
    next_wake      = 1'b0;
    next_rdata     = 16'h0000;
    for (int i = 0; i < DEPTH; i++) begin
      next_fifo[i] = fifo[i];
    end
    want_irq = 1'b0;

    // Prescaler counts rising edges, unchanged across active mode changes
    // Limitation: a leftover count may make the first capture early
    // Counting is held while stopped so Sleep never advances it
    if ((mode == icef_pkg::ICEF_PRE4 || mode == icef_pkg::ICEF_PRE16) && rise && !stopped) begin
      next_pre_cnt = pre_hit ? 4'h0 : pre_cnt + 4'h1;
    end

    // Read path: oldest entry out, rest shift forward
    // Shifting costs muxes but keeps the output always at entry 0
    // An empty read moves nothing; its data is stale by design
    // While overflowed, the fourth read clears the condition
    if (rd_fifo) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_fifo[i] = fifo[i+1];
      end
      next_fill = fill - ONE_CNT;
      if (ovf) begin
        next_ovf_reads = ovf_reads + ONE_CNT;
        if (ovf_reads == FULL_CNT - ONE_CNT) begin
          next_ovf       = 1'b0;
          next_ovf_reads = ZERO_CNT;
        end
      end
    end

    // Write path; a read in the same cycle shifts first but does not make room in a full buffer
    // Index uses the fill after any read so no entry is skipped
    // Event counter counts stored words only
    // Count zero and both-edges modes flag every event,
    // even when the word itself cannot be stored
    if (do_write) begin
      next_fifo[next_fill[CW-2:0]] = timer_count;
      next_fill = next_fill + ONE_CNT;
      if (mode == icef_pkg::ICEF_BOTH || cfg.captures_per_interrupt == 2'h0) begin
        want_irq = 1'b1;
      end else if (ev_cnt == cfg.captures_per_interrupt) begin
        want_irq    = 1'b1;
        next_ev_cnt = 2'h0;
      end else begin
        next_ev_cnt = ev_cnt + 2'h1;
      end
    end else if (capture_ev && (mode == icef_pkg::ICEF_BOTH ||
                 cfg.captures_per_interrupt == 2'h0)) begin
      want_irq = 1'b1;
    end
    if (do_ovf) begin
      next_ovf = 1'b1;
    end

    // Sleep-interrupt mode: rising edge wakes and interrupts
    // No timer is needed here; nothing is stored while stopped
    // Priority must beat the CPU level for the flag to rise
    if (mode == icef_pkg::ICEF_SLEEPIRQ && rise && stopped) begin
      next_wake = irq_en;
      want_irq  = irq_en && irq_prio > cpu_priority;
    end

    // Empty buffer realigns the event count
    // Keeps the interrupt cadence tied to what the FIFO holds
    if (next_fill == ZERO_CNT) begin
      next_ev_cnt = 2'h0;
    end

    // Register writes
    // Status bits are read-only; writes to them are dropped
    // Flag bit: writing zero clears, writing one does nothing
    // Unmapped address three is ignored entirely
    if (reg_wr && reg_addr == icef_pkg::ADDR_CONTROL_ONE) begin
      next_cfg.capture_mode_select    = icef_pkg::icef_mode_t'(reg_wdata[icef_pkg::MODE_LSB +: 3]);
      next_cfg.captures_per_interrupt = reg_wdata[icef_pkg::CPI_LSB +: 2];
      next_cfg.stop_in_idle           = reg_wdata[icef_pkg::SIDL_BIT];
    end
    if (reg_wr && reg_addr == icef_pkg::ADDR_IRQ_CTRL) begin
      next_irq_en   = reg_wdata[icef_pkg::IRQE_BIT];
      next_irq_prio = reg_wdata[icef_pkg::PRIO_LSB +: 3];
      if (!reg_wdata[icef_pkg::IRQF_BIT]) begin
        next_irq_flag = 1'b0;
      end
    end
    // Delayed flag set wins over a software clear
    // Losing the set would drop an interrupt silently
    if (irq_pipe[IRQ_DELAY_W-1]) begin
      next_irq_flag = 1'b1;
    end

    // Mode off clears the prescaler, overflow and FIFO
    // Acts both on the write itself and while the mode stays off,
    // so a capture in the write cycle cannot slip into the buffer
    // FIFO words are not wiped; emptiness is carried by the fill count
    if (mode_off_wr || mode == icef_pkg::ICEF_OFF) begin
      next_pre_cnt   = 4'h0;
      next_fill      = ZERO_CNT;
      next_ovf       = 1'b0;
      next_ovf_reads = ZERO_CNT;
      next_ev_cnt    = 2'h0;
      want_irq       = 1'b0;
    end

    next_irq_pipe = {irq_pipe[IRQ_DELAY_W-2:0], want_irq};

    // Read data: one cycle after the strobe
    // Zero outside that cycle, so the port never shows old data
    // Status reflects state before any same-cycle update
    // Unused bits read as zero
    if (reg_rd) begin
      case (reg_addr)
        icef_pkg::ADDR_CONTROL_ONE: begin
          next_rdata[icef_pkg::MODE_LSB +: 3] = cfg.capture_mode_select;
          next_rdata[icef_pkg::BNE_BIT]       = fill != ZERO_CNT;
          next_rdata[icef_pkg::OV_BIT]        = ovf;
          next_rdata[icef_pkg::CPI_LSB +: 2]  = cfg.captures_per_interrupt;
          next_rdata[icef_pkg::SIDL_BIT]      = cfg.stop_in_idle;
        end
        icef_pkg::ADDR_FIFO_PORT: next_rdata = 16'(fifo[0]);
        icef_pkg::ADDR_IRQ_CTRL: begin
          next_rdata[icef_pkg::IRQF_BIT]      = irq_flag;
          next_rdata[icef_pkg::IRQE_BIT]      = irq_en;
          next_rdata[icef_pkg::PRIO_LSB +: 3] = irq_prio;
        end
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State registers
  // Asynchronous reset loads constants only
  // Reset clears prescaler, FIFO fill, overflow and both counters
  // FIFO words are cleared too, though software must not rely on them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg.capture_mode_select    <= icef_pkg::ICEF_OFF;
      cfg.captures_per_interrupt <= icef_pkg::CPI_RST;
      cfg.stop_in_idle           <= 1'b0;
      irq_en    <= 1'b0;
      irq_prio  <= icef_pkg::PRIO_RST;
      irq_flag  <= 1'b0;
      pre_cnt   <= 4'h0;
      fill      <= ZERO_CNT;
      ovf       <= 1'b0;
      ev_cnt    <= 2'h0;
      ovf_reads <= ZERO_CNT;
      irq_pipe  <= '0;
      wake      <= 1'b0;
      rdata     <= 16'h0000;
      for (int i = 0; i < DEPTH; i++) begin
        fifo[i] <= '0;
      end
    end else begin
      cfg       <= next_cfg;
      irq_en    <= next_irq_en;
      irq_prio  <= next_irq_prio;
      irq_flag  <= next_irq_flag;
      pre_cnt   <= next_pre_cnt;
      fill      <= next_fill;
      ovf       <= next_ovf;
      ev_cnt    <= next_ev_cnt;
      ovf_reads <= next_ovf_reads;
      irq_pipe  <= next_irq_pipe;
      wake      <= next_wake;
      rdata     <= next_rdata;
      for (int i = 0; i < DEPTH; i++) begin
        fifo[i] <= next_fifo[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  // No logic between the registers and the ports,
  // so the outputs are glitch-free
  // The interrupt output is the flag itself, a level
  always_comb begin
    reg_rdata    = rdata;
    capture_irq  = irq_flag;
    wake_request = wake;
  end
endmodule : icef_capture

//--- tb/icef_assertions.sv
// Checker: port-level timing and status relations of the capture channel
`timescale 1ns/1ns
module icef_assertions (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        capture_input_pin,
  input wire logic        sleep_mode,
  input wire logic [1:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        capture_irq,
  input wire logic        wake_request
);
  logic [15:0] cfg_q;
  logic        pin_q;
  logic [3:0]  since_pin;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the control word; age of the last pin change, saturating
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q     <= 16'h0000;
      pin_q     <= 1'b0;
      since_pin <= 4'hf;
    end else begin
      if (reg_wr && reg_addr == icef_pkg::ADDR_CONTROL_ONE) begin
        cfg_q <= reg_wdata & 16'h2067;
      end
      pin_q     <= capture_input_pin;
      since_pin <= (pin_q != capture_input_pin) ? 4'h0 : since_pin + {3'h0, since_pin != 4'hf};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Control reads and the sync window after a pin change
  sequence s_ctrl_rd;
    reg_rd && reg_addr == icef_pkg::ADDR_CONTROL_ONE;
  endsequence
  sequence s_pin_recent;
    since_pin >= 4'h2 && since_pin <= 4'ha;
  endsequence
  property p_irq_after_edge; $rose(capture_irq) |-> s_pin_recent; endproperty
  a_irq_after_edge: assert property (p_irq_after_edge)
    else $error("flag rose with no recent pin edge");
  property p_wake_mode; wake_request |-> cfg_q[2:0] == 3'h7 && since_pin <= 4'ha; endproperty
  a_wake_mode: assert property (p_wake_mode)
    else $error("wake outside sleep interrupt mode");
  property p_wake_pulse; wake_request |=> !wake_request; endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake pulse longer than one cycle");
  property p_off_empty; s_ctrl_rd ##0 cfg_q[2:0] == 3'h0 |=> reg_rdata[4:3] == 2'h0; endproperty
  a_off_empty: assert property (p_off_empty)
    else $error("status not cleared while off");
  property p_ov_exempt;
    s_ctrl_rd ##0 (cfg_q[6:5] == 2'h0 || cfg_q[2:0] == 3'h1) |=> !reg_rdata[4];
  endproperty
  a_ov_exempt: assert property (p_ov_exempt)
    else $error("overflow set in exempt setting");
  property p_cfg_echo; s_ctrl_rd |=> (reg_rdata & 16'h2067) == $past(cfg_q); endproperty
  a_cfg_echo: assert property (p_cfg_echo)
    else $error("control fields read back wrong");
  property p_ov_full; s_ctrl_rd |=> !reg_rdata[4] || reg_rdata[3]; endproperty
  a_ov_full: assert property (p_ov_full)
    else $error("overflow with empty buffer");
  property p_sleep_irq; $rose(capture_irq) && sleep_mode |-> cfg_q[2:0] == 3'h7; endproperty
  a_sleep_irq: assert property (p_sleep_irq)
    else $error("flag in sleep outside sleep interrupt mode");
  property p_quiet_rdata; reg_rdata != 16'h0000 |-> $past(reg_rd); endproperty
  a_quiet_rdata: assert property (p_quiet_rdata)
    else $error("read data without a read");
endmodule : icef_assertions

bind icef_capture icef_assertions u_chk (
  .clk(clk), .rst_b(rst_b), .capture_input_pin(capture_input_pin), .sleep_mode(sleep_mode),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .capture_irq(capture_irq), .wake_request(wake_request)
);

//--- tb/icef_pin_model.sv
// Partner model: external pulse source and free-running dedicated timer
`timescale 1ns/1ns
module icef_pin_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  output logic             pin,
  output logic [15:0]      tmr
);
  initial pin = 1'b0;
  // Timer steps every cycle so capture spacing equals edge spacing
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) tmr <= 16'h0000;
    else tmr <= tmr + 16'h0001;
  end
  // Level held at least 9 cycles: meets minimum high and low time
  task automatic drive(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (8) @(posedge clk);
  endtask : drive
endmodule : icef_pin_model

//--- tb/icef_capture_tb_top.sv
// Self-checking bench for the input capture channel
`timescale 1ns/1ns
module icef_capture_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        idle_mode = 1'b0;
  logic [2:0]  cpu_priority = 3'h0;
  logic [1:0]  reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata, timer_count;
  logic        capture_input_pin, capture_irq, wake_request;
  logic        wake_seen = 1'b0;
  int          bad_count = 0;
  int          compares = 0;
  always #10 clk = ~clk;
  // Wake is a one-cycle pulse; keep it for later inspection
  always @(posedge clk) begin
    if (wake_request === 1'b1) wake_seen <= 1'b1;
  end
  icef_pin_model u_pin (.clk(clk), .rst_b(rst_b), .pin(capture_input_pin), .tmr(timer_count));
  icef_capture u_dut (
    .clk(clk), .rst_b(rst_b), .capture_input_pin(capture_input_pin),
    .timer_count(timer_count), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .cpu_priority(cpu_priority), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_irq(capture_irq), .wake_request(wake_request)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the strobe; sampled 1 ns into it
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic stat(input logic [15:0] e);
    logic [15:0] d;
    rd(icef_pkg::ADDR_CONTROL_ONE, d);
    chk(d & 16'h0018, e);
  endtask : stat
  function automatic logic [15:0] cfg(input icef_pkg::icef_mode_t m, input logic [1:0] c,
                                      input logic s);
    return {2'h0, s, 6'h00, c, 2'h0, m};
  endfunction : cfg
  // Pulse period is 20 cycles, rise to fall 9; flag checked then cleared
  task automatic burst(input logic [15:0] c, input int n, input logic [15:0] irq_mask);
    wr(icef_pkg::ADDR_CONTROL_ONE, c);
    for (int i = 0; i < n; i++) begin
      u_pin.drive(1'b1);
      u_pin.drive(1'b0);
      chk({15'h0, capture_irq}, {15'h0, irq_mask[i]});
      wr(icef_pkg::ADDR_IRQ_CTRL, 16'h0000);
    end
  endtask : burst
  // Spacing between entries proves order and that nothing was overwritten
  task automatic drain(input int n, input logic [15:0] odd, input logic [15:0] even);
    logic [15:0] d, p;
    for (int i = 0; i < n; i++) begin
      rd(icef_pkg::ADDR_FIFO_PORT, d);
      if (i > 0) chk(d - p, i[0] ? odd : even);
      p = d;
    end
  endtask : drain
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state();
    logic [15:0] d;
    rd(icef_pkg::ADDR_CONTROL_ONE, d);
    chk(d, 16'h0000);
    rd(icef_pkg::ADDR_IRQ_CTRL, d);
    chk(d, 16'h0000);
    wr(2'h3, 16'hffff);
    rd(2'h3, d);
    chk(d, 16'h0000);
  endtask : t_reset_state
  task automatic t_fifo_order();
    burst(cfg(icef_pkg::ICEF_RISE, 2'h1, 1'b0), 4, 16'h000a);
    stat(16'h0008);
    drain(4, 16'h0014, 16'h0014);
    stat(16'h0000);
    // Empty read: value is meaningless, only state is judged
    drain(1, 16'h0000, 16'h0000);
    stat(16'h0000);
    burst(cfg(icef_pkg::ICEF_RISE, 2'h1, 1'b0), 1, 16'h0000);
    drain(1, 16'h0000, 16'h0000);
    burst(cfg(icef_pkg::ICEF_RISE, 2'h1, 1'b0), 1, 16'h0000);
    drain(1, 16'h0000, 16'h0000);
  endtask : t_fifo_order
  task automatic t_overflow();
    burst(cfg(icef_pkg::ICEF_RISE, 2'h3, 1'b0), 5, 16'h0008);
    stat(16'h0018);
    drain(4, 16'h0014, 16'h0014);
    stat(16'h0000);
  endtask : t_overflow
  task automatic t_both_fall();
    burst(cfg(icef_pkg::ICEF_BOTH, 2'h3, 1'b0), 3, 16'h0007);
    stat(16'h0008);
    drain(4, 16'h0009, 16'h000b);
    wr(icef_pkg::ADDR_CONTROL_ONE, 16'h0000);
    burst(cfg(icef_pkg::ICEF_FALL, 2'h0, 1'b0), 5, 16'h001f);
    stat(16'h0008);
    drain(4, 16'h0014, 16'h0014);
    wr(icef_pkg::ADDR_CONTROL_ONE, 16'h0000);
    stat(16'h0000);
  endtask : t_both_fall
  task automatic t_prescale();
    burst(cfg(icef_pkg::ICEF_PRE4, 2'h0, 1'b0), 2, 16'h0000);
    wr(icef_pkg::ADDR_CONTROL_ONE, 16'h0000);
    burst(cfg(icef_pkg::ICEF_PRE4, 2'h0, 1'b0), 3, 16'h0000);
    stat(16'h0000);
    burst(cfg(icef_pkg::ICEF_PRE4, 2'h0, 1'b0), 1, 16'h0001);
    burst(cfg(icef_pkg::ICEF_PRE4, 2'h0, 1'b0), 2, 16'h0000);
    burst(cfg(icef_pkg::ICEF_PRE16, 2'h0, 1'b0), 13, 16'h0000);
    burst(cfg(icef_pkg::ICEF_PRE16, 2'h0, 1'b0), 1, 16'h0001);
    wr(icef_pkg::ADDR_CONTROL_ONE, 16'h0000);
  endtask : t_prescale
  task automatic t_power();
    sleep_mode <= 1'b1;
    burst(cfg(icef_pkg::ICEF_RISE, 2'h0, 1'b0), 1, 16'h0000);
    chk({15'h0, wake_seen}, 16'h0000);
    // Enable with priority 5, above the idle CPU level
    wr(icef_pkg::ADDR_IRQ_CTRL, 16'h0016);
    burst(cfg(icef_pkg::ICEF_SLEEPIRQ, 2'h0, 1'b0), 1, 16'h0001);
    chk({15'h0, wake_seen}, 16'h0001);
    sleep_mode <= 1'b0;
    idle_mode  <= 1'b1;
    burst(cfg(icef_pkg::ICEF_RISE, 2'h0, 1'b0), 1, 16'h0001);
    burst(cfg(icef_pkg::ICEF_RISE, 2'h0, 1'b1), 1, 16'h0000);
    idle_mode <= 1'b0;
    rst_b     <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    stat(16'h0000);
  endtask : t_power
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset_state();
    t_fifo_order();
    t_overflow();
    t_both_fall();
    t_prescale();
    t_power();
    close_out();
  end
  // Hang guard: far beyond the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule : icef_capture_tb_top
